//--- pkg/amux_regs.svh
// Purpose: Register offsets, field positions and reset values of the mux select block.
// Assumes: Byte addresses on a 32-bit APB bus, one aligned word per register.
// Notes:   Definitions only.
`ifndef AMUX_REGS_SVH
`define AMUX_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define AMUX_OFS_GRP_SEL   8'h00
`define AMUX_OFS_CH0_SEL   8'h04
`define AMUX_OFS_SCAN      8'h08
`define AMUX_OFS_PIN_CFG   8'h0C
`define AMUX_OFS_CTRL      8'h10
`define AMUX_OFS_STATUS    8'h14

// ----------------------------------------------------------------------------
// Implemented bit masks and reset values
// ----------------------------------------------------------------------------
`define AMUX_MSK_GRP_SEL   16'h0707
`define AMUX_MSK_CH0_SEL   16'h9F9F
`define AMUX_MSK_SCAN      16'h003F
`define AMUX_MSK_PIN_CFG   16'h003F
`define AMUX_MSK_CTRL      16'h0007
`define AMUX_RST_REG       16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AMUX_GRP_POS_A     0
`define AMUX_GRP_NEG_A_LO  1
`define AMUX_GRP_POS_B     8
`define AMUX_GRP_NEG_B_LO  9
`define AMUX_CH0_POS_A_LO  0
`define AMUX_CH0_NEG_A     7
`define AMUX_CH0_POS_B_LO  8
`define AMUX_CH0_NEG_B     15
`define AMUX_CTRL_ALT      0
`define AMUX_CTRL_SCAN     1
`define AMUX_CTRL_RES      2
`define AMUX_SAMPLE_B_MAX  5'h09
`define AMUX_NEG_PIN       4'h1

`endif

//--- pkg/amux_pkg.sv
// Purpose: Types shared by the mux select block and its bench.
// Assumes: APB with 8-bit byte address and 32-bit data.
// Notes:   Offsets and field positions live in amux_regs.svh.
package amux_pkg;

  // --------------------------------------------------------------------------
  // Bus carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } amux_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } amux_apb_rsp_t;

  // --------------------------------------------------------------------------
  // Routing of one converter input
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    AMUX_RT_OPEN = 2'h0,
    AMUX_RT_PIN  = 2'h1,
    AMUX_RT_NREF = 2'h2,
    AMUX_RT_AGND = 2'h3
  } amux_kind_t;

  typedef struct packed {
    amux_kind_t kind;
    logic [3:0] ain;
  } amux_route_t;

  // Sample phase, one-hot.
  typedef enum logic [1:0] {
    AMUX_PH_A = 2'b01,
    AMUX_PH_B = 2'b10
  } amux_phase_t;

  // --------------------------------------------------------------------------
  // Whole state of the block
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [15:0]       grp_sel;
    logic [15:0]       ch0_sel;
    logic [15:0]       scan_mask;
    logic [15:0]       pin_cfg;
    logic [15:0]       ctrl;
    amux_phase_t       phase;
    logic [2:0]        scan_idx;
    logic [31:0]       rdata;
    amux_route_t       ch0_pos;
    amux_route_t       ch0_neg;
    amux_route_t [2:0] grp_pos;
    amux_route_t       grp_neg;
    logic              grp_en;
  } amux_state_t;

endpackage : amux_pkg

//--- rtl/amux_sel.sv
// Purpose: Input multiplexer selection for a multi-channel converter, with APB registers.
// Assumes: sample_strobe comes from converter logic on the same clock.
// Notes:   Routes are registered and follow a register write by one cycle.
//
// Contract
// - 10-bit mode, group positive bit clear routes inputs 0,1,2 to channels 1,2,3.
// - Small variant, bit set routes input 3 to channel 1, channels 2-3 open.
// - Large variant, bit set routes inputs 3,4,5 to channels 1,2,3.
// - Group negative codes 00 and 01 select the negative reference; 10, 11 reserved.
// - 12-bit mode leaves channels 1-3 unused whatever their codes.
// - Channel 0 sample B negative bit set picks input 1, else negative reference.
// - Channel 0 sample A negative bit set picks input 1, else negative reference.
// - Channel 0 sample B positive field picks input by binary value, 0 to 9.
// - Channel 0 sample A positive field picks input by value, 0-3 on small variant.
// - On large variant sample A positive reaches inputs 0 to 5.
// - Each scan mask bit includes its input in the scan when set.
// - Scanning an input absent from the package converts the negative reference.
// - Set pin bit gives digital mode, read path on, mux input at ground.
// - Clear pin bit gives analog mode, read path off, pin voltage sampled.
// - All six pin bits read and write; absent pins ignore them.
// - Unimplemented bits read zero and ignore writes.
// - All implemented fields clear at reset.
// - Resolution bit set selects single-channel 12-bit, clear four-channel 10-bit.
// - Scan enable makes channel 0 positive in sample A follow the scan.
// - Alternate mode uses sample A then sample B selects; otherwise always A.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/10ps

`include "amux_regs.svh"

module amux_sel #(
  parameter int PIN_COUNT = 6
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire amux_pkg::amux_apb_req_t apb_req,
  output      amux_pkg::amux_apb_rsp_t apb_rsp,
  input  wire logic                    sample_strobe,
  output      amux_pkg::amux_route_t   ch0_pos_route,
  output      amux_pkg::amux_route_t   ch0_neg_route,
  output      amux_pkg::amux_route_t   ch1_pos_route,
  output      amux_pkg::amux_route_t   ch2_pos_route,
  output      amux_pkg::amux_route_t   ch3_pos_route,
  output      amux_pkg::amux_route_t   grp_neg_route,
  output      logic                    grp_enable,
  output      logic                    resolution_mode_select,
  output      logic                    sample_b_active,
  output      logic [5:0]              pin_digital_mode_mask,
  output      logic [5:0]              port_read_enable
);
  import amux_pkg::*;

  // --------------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------------
  // Only the two package variants are served: four or six analog inputs.
  if (PIN_COUNT != 4 && PIN_COUNT != 6) begin : g_bad_pins
    $error("PIN_COUNT must be 4 or 6");
  end

  localparam logic [4:0] PIN_LIMIT = 5'(PIN_COUNT);
  localparam logic       LARGE_PKG = (PIN_COUNT == 6);

  // --------------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------------
  // Routes an input index to its pin, or to the reference or ground.
  // Absent inputs see the negative reference, so their pin bits never matter.
  function automatic amux_route_t route_pin(input logic [4:0] idx,
                                            input logic [5:0] cfg);
    amux_route_t r;
    r.ain = idx[3:0];
    if (idx >= PIN_LIMIT) begin
      r.kind = AMUX_RT_NREF;
    end else if (cfg[idx[2:0]]) begin
      r.kind = AMUX_RT_AGND;
    end else begin
      r.kind = AMUX_RT_PIN;
    end
    return r;
  endfunction : route_pin

  // A fixed connection to the converter negative reference.
  function automatic amux_route_t route_ref();
    amux_route_t r;
    r.kind = AMUX_RT_NREF;
    r.ain  = 4'h0;
    return r;
  endfunction : route_ref

  // A channel input left unconnected.
  function automatic amux_route_t route_open();
    amux_route_t r;
    r.kind = AMUX_RT_OPEN;
    r.ain  = 4'h0;
    return r;
  endfunction : route_open

  // Next set mask bit above idx, wrapping; idx stays if the mask is empty.
  function automatic logic [2:0] next_scan(input logic [5:0] mask,
                                           input logic [2:0] idx);
    logic [2:0] res;
    logic [2:0] cand;
    logic       found;
    res   = idx;
    cand  = idx;
    found = 1'b0;
    for (int i = 0; i < 6; i++) begin
      cand = (cand == 3'h5) ? 3'h0 : 3'(cand + 3'h1);
      if (!found && mask[cand]) begin
        res   = cand;
        found = 1'b1;
      end
    end
    return res;
  endfunction : next_scan

  // Masked register update, so unimplemented bits never store a one.
  function automatic logic [15:0] masked(input logic [31:0] wd,
                                         input logic [15:0] msk);
    return wd[15:0] & msk;
  endfunction : masked

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  amux_state_t st_q;
  amux_state_t st_d;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  logic       setup_ph;
  logic       access_ph;
  logic       hit;
  logic [7:0] addr;

  // The slave answers in the first access cycle, so pready is high in every access cycle and low otherwise.
  assign addr      = {apb_req.paddr[7:2], 2'b00};
  assign setup_ph  = apb_req.psel && !apb_req.penable;
  assign access_ph = apb_req.psel && apb_req.penable;
  assign hit       = (addr == `AMUX_OFS_GRP_SEL) || (addr == `AMUX_OFS_CH0_SEL) ||
                     (addr == `AMUX_OFS_SCAN)    || (addr == `AMUX_OFS_PIN_CFG) ||
                     (addr == `AMUX_OFS_CTRL)    || (addr == `AMUX_OFS_STATUS);

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  logic        use_b;
  logic        res12;
  logic        scan_on;
  logic [4:0]  pos_a;
  logic [4:0]  pos_b;
  logic [4:0]  ch0_idx;
  logic        neg_in1;
  logic        grp_pos_bit;
  logic [1:0]  grp_neg_code;
  logic [5:0]  cfg6;
  logic [5:0]  mask6;
  amux_route_t r0;
  amux_route_t r1;
  amux_route_t r2;

  always_comb begin
    st_d = st_q;
    r0   = route_open();
    r1   = route_open();
    r2   = route_open();

    // Register writes land on the access edge only.
    if (access_ph && apb_req.pwrite) begin
      unique case (addr)
        `AMUX_OFS_GRP_SEL: st_d.grp_sel   = masked(apb_req.pwdata, `AMUX_MSK_GRP_SEL);
        `AMUX_OFS_CH0_SEL: st_d.ch0_sel   = masked(apb_req.pwdata, `AMUX_MSK_CH0_SEL);
        `AMUX_OFS_SCAN:    st_d.scan_mask = masked(apb_req.pwdata, `AMUX_MSK_SCAN);
        `AMUX_OFS_PIN_CFG: st_d.pin_cfg   = masked(apb_req.pwdata, `AMUX_MSK_PIN_CFG);
        `AMUX_OFS_CTRL:    st_d.ctrl      = masked(apb_req.pwdata, `AMUX_MSK_CTRL);
        default: ;
      endcase
    end

    // Read data is captured in the setup cycle and held for the access cycle.
    if (setup_ph) begin
      unique case (addr)
        `AMUX_OFS_GRP_SEL: st_d.rdata = {16'h0000, st_q.grp_sel};
        `AMUX_OFS_CH0_SEL: st_d.rdata = {16'h0000, st_q.ch0_sel};
        `AMUX_OFS_SCAN:    st_d.rdata = {16'h0000, st_q.scan_mask};
        `AMUX_OFS_PIN_CFG: st_d.rdata = {16'h0000, st_q.pin_cfg};
        `AMUX_OFS_CTRL:    st_d.rdata = {16'h0000, st_q.ctrl};
        `AMUX_OFS_STATUS:  st_d.rdata = {25'h0000000, st_q.scan_idx, 3'h0,
                                         st_q.phase == AMUX_PH_B};
        default:           st_d.rdata = 32'h00000000;
      endcase
    end

    // Sample sequencing: alternate A and B, and step the scan after a sample A.
    if (sample_strobe) begin
      unique case (st_q.phase)
        AMUX_PH_A: begin
          if (st_q.ctrl[`AMUX_CTRL_ALT]) begin
            st_d.phase = AMUX_PH_B;
          end
          if (st_q.ctrl[`AMUX_CTRL_SCAN]) begin
            st_d.scan_idx = next_scan(st_q.scan_mask[5:0], st_q.scan_idx);
          end
        end
        AMUX_PH_B: begin
          st_d.phase = AMUX_PH_A;
        end
        default: begin
          st_d.phase = AMUX_PH_A;
        end
      endcase
    end
    // Leaving alternate mode returns to sample A at once.
    if (!st_q.ctrl[`AMUX_CTRL_ALT]) begin
      st_d.phase = AMUX_PH_A;
    end
    // A scan index that the mask no longer holds moves to a held one.
    if (st_q.ctrl[`AMUX_CTRL_SCAN] && !st_q.scan_mask[st_q.scan_idx]) begin
      st_d.scan_idx = next_scan(st_q.scan_mask[5:0], st_q.scan_idx);
    end

    // Channel 0 positive input.
    use_b   = (st_q.phase == AMUX_PH_B);
    res12   = st_q.ctrl[`AMUX_CTRL_RES];
    scan_on = st_q.ctrl[`AMUX_CTRL_SCAN];
    cfg6    = st_q.pin_cfg[5:0];
    mask6   = st_q.scan_mask[5:0];
    pos_a   = st_q.ch0_sel[`AMUX_CH0_POS_A_LO +: 5];
    pos_b   = st_q.ch0_sel[`AMUX_CH0_POS_B_LO +: 5];
    if (use_b) begin
      ch0_idx = (pos_b > `AMUX_SAMPLE_B_MAX) ? 5'h1F : pos_b;
    end else if (scan_on) begin
      ch0_idx = {2'b00, st_q.scan_idx};
    end else begin
      ch0_idx = pos_a;
    end
    if (!use_b && scan_on && mask6 == 6'h00) begin
      st_d.ch0_pos = route_ref();
    end else begin
      st_d.ch0_pos = route_pin(ch0_idx, cfg6);
    end

    // Channel 0 negative input.
    neg_in1 = use_b ? st_q.ch0_sel[`AMUX_CH0_NEG_B]
                    : st_q.ch0_sel[`AMUX_CH0_NEG_A];
    if (neg_in1) begin
      st_d.ch0_neg = route_pin({1'b0, `AMUX_NEG_PIN}, cfg6);
    end else begin
      st_d.ch0_neg = route_ref();
    end

    // Channels 1 to 3.
    grp_pos_bit  = use_b ? st_q.grp_sel[`AMUX_GRP_POS_B]
                         : st_q.grp_sel[`AMUX_GRP_POS_A];
    grp_neg_code = use_b ? st_q.grp_sel[`AMUX_GRP_NEG_B_LO +: 2]
                         : st_q.grp_sel[`AMUX_GRP_NEG_A_LO +: 2];
    if (!grp_pos_bit) begin
      r0 = route_pin(5'h00, cfg6);
      r1 = route_pin(5'h01, cfg6);
      r2 = route_pin(5'h02, cfg6);
    end else if (LARGE_PKG) begin
      r0 = route_pin(5'h03, cfg6);
      r1 = route_pin(5'h04, cfg6);
      r2 = route_pin(5'h05, cfg6);
    end else begin
      r0 = route_pin(5'h03, cfg6);
    end
    if (res12) begin
      // Every code is reserved here, so the group stays disconnected.
      st_d.grp_en  = 1'b0;
      st_d.grp_pos = {route_open(), route_open(), route_open()};
      st_d.grp_neg = route_open();
    end else begin
      st_d.grp_en  = 1'b1;
      st_d.grp_pos = {r2, r1, r0};
      st_d.grp_neg = grp_neg_code[1] ? route_open() : route_ref();
    end
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  // Every field but the phase, which loads sample A, clears at reset, including the registered routes.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q.grp_sel   <= `AMUX_RST_REG;
      st_q.ch0_sel   <= `AMUX_RST_REG;
      st_q.scan_mask <= `AMUX_RST_REG;
      st_q.pin_cfg   <= `AMUX_RST_REG;
      st_q.ctrl      <= `AMUX_RST_REG;
      st_q.phase     <= AMUX_PH_A;
      st_q.scan_idx  <= 3'h0;
      st_q.rdata     <= 32'h00000000;
      st_q.ch0_pos   <= '0;
      st_q.ch0_neg   <= '0;
      st_q.grp_pos   <= '0;
      st_q.grp_neg   <= '0;
      st_q.grp_en    <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Unmapped addresses answer with pslverr and read zero.
  always_comb begin
    apb_rsp.pready  = access_ph;
    apb_rsp.pslverr = access_ph && !hit;
    apb_rsp.prdata  = st_q.rdata;
  end

  // Pin mode follows the stored bits; absent pins are driven but unused.
  assign ch0_pos_route          = st_q.ch0_pos;
  assign ch0_neg_route          = st_q.ch0_neg;
  assign ch1_pos_route          = st_q.grp_pos[0];
  assign ch2_pos_route          = st_q.grp_pos[1];
  assign ch3_pos_route          = st_q.grp_pos[2];
  assign grp_neg_route          = st_q.grp_neg;
  assign grp_enable             = st_q.grp_en;
  assign resolution_mode_select = st_q.ctrl[`AMUX_CTRL_RES];
  assign sample_b_active        = (st_q.phase == AMUX_PH_B);
  assign pin_digital_mode_mask  = st_q.pin_cfg[5:0];
  assign port_read_enable       = st_q.pin_cfg[5:0];

endmodule : amux_sel

//--- dv/amux_sel_assertions.sv
// Purpose: Concurrent checks on the ports of the mux select block.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Bound into every instance of amux_sel.
`timescale 1ns/10ps

`include "amux_regs.svh"

module amux_sel_assertions #(
  parameter int PIN_COUNT = 6
) (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire amux_pkg::amux_apb_req_t apb_req,
  input wire amux_pkg::amux_apb_rsp_t apb_rsp,
  input wire logic                    sample_strobe,
  input wire amux_pkg::amux_route_t   ch0_pos_route,
  input wire amux_pkg::amux_route_t   ch0_neg_route,
  input wire amux_pkg::amux_route_t   ch1_pos_route,
  input wire amux_pkg::amux_route_t   ch2_pos_route,
  input wire amux_pkg::amux_route_t   ch3_pos_route,
  input wire amux_pkg::amux_route_t   grp_neg_route,
  input wire logic                    grp_enable,
  input wire logic                    resolution_mode_select,
  input wire logic                    sample_b_active,
  input wire logic [5:0]              pin_digital_mode_mask,
  input wire logic [5:0]              port_read_enable
);
  import amux_pkg::*;

  // --------------------------------------------------------------------------
  // Port relations
  // --------------------------------------------------------------------------
  // All checks share one clock, so reset disables them in one place.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_unmapped_error: assert property (apb_req.psel && apb_req.penable && apb_req.paddr[7:2] > 6'h05
    |-> apb_rsp.pready && apb_rsp.pslverr) else $error("unmapped access not flagged");
  chk_read_upper_zero: assert property (
    apb_req.psel && apb_req.penable && !apb_req.pwrite |-> apb_rsp.prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_pin_mask_write: assert property (
    apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == `AMUX_OFS_PIN_CFG
    |-> ##2 pin_digital_mode_mask == $past(apb_req.pwdata[5:0], 2))
    else $error("pin mode mask did not follow write");
  chk_read_path_copy: assert property (port_read_enable == pin_digital_mode_mask)
    else $error("read path differs from pin mode");
  chk_group_off_wide: assert property (
    resolution_mode_select && $past(resolution_mode_select) |-> !grp_enable)
    else $error("channels 1-3 enabled in 12-bit mode");
  chk_b_after_strobe: assert property ($rose(sample_b_active) |-> $past(sample_strobe))
    else $error("sample B without strobe");
  chk_neg_pin_one: assert property (
    ch0_neg_route.kind == AMUX_RT_PIN |-> ch0_neg_route.ain == 4'h1)
    else $error("channel 0 negative on wrong input");
  chk_ch1_pin_set: assert property (
    ch1_pos_route.kind == AMUX_RT_PIN |-> ch1_pos_route.ain inside {4'h0, 4'h3})
    else $error("channel 1 on wrong input");
  chk_grp_neg_kind: assert property (
    grp_neg_route.kind inside {AMUX_RT_OPEN, AMUX_RT_NREF})
    else $error("group negative route wrong");
endmodule : amux_sel_assertions

bind amux_sel amux_sel_assertions #(.PIN_COUNT(PIN_COUNT)) u_amux_sel_assertions (
  .clock(clock), .rst_n(rst_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .sample_strobe(sample_strobe), .ch0_pos_route(ch0_pos_route),
  .ch0_neg_route(ch0_neg_route), .ch1_pos_route(ch1_pos_route),
  .ch2_pos_route(ch2_pos_route), .ch3_pos_route(ch3_pos_route),
  .grp_neg_route(grp_neg_route), .grp_enable(grp_enable),
  .resolution_mode_select(resolution_mode_select), .sample_b_active(sample_b_active),
  .pin_digital_mode_mask(pin_digital_mode_mask), .port_read_enable(port_read_enable));

//--- dv/amux_core_model.sv
// Purpose: Converter core model that issues one sample strobe per request.
// Assumes: Requests are one-cycle pulses on the system clock.
// Notes:   The delay lets the bench answer promptly or slowly.
`timescale 1ns/10ps

module amux_core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       fire,
  input  wire logic [3:0] gap,
  output logic            sample_strobe
);
  logic [4:0] cnt_q;

  // The strobe is one cycle wide because the core takes exactly one sample per request.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q         <= 5'h00;
      sample_strobe <= 1'b0;
    end else begin
      sample_strobe <= (cnt_q == 5'h01);
      if (fire) begin
        cnt_q <= {1'b0, gap} + 5'h01;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule : amux_core_model

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the mux select block.
// Assumes: Large package variant with six analog pins.
// Notes:   Strobes come from the core model after a random delay.
`timescale 1ns/10ps

`include "amux_regs.svh"

module tb_top;
  import amux_pkg::*;

  logic          clock;
  logic          rst_n;
  amux_apb_req_t req;
  amux_apb_rsp_t rsp;
  logic          fire;
  logic [3:0]    gap;
  logic          strobe;
  amux_route_t   r0p, r0n, r1, r2, r3, rgn;
  logic          grp_en, res_sel, samp_b;
  logic [5:0]    dig_mask, rd_en;
  logic [31:0]   q, v;
  logic          err;
  int            n_mismatch, num_checks, seed, i;
  logic [15:0]   masks [5] = '{`AMUX_MSK_GRP_SEL, `AMUX_MSK_CH0_SEL, `AMUX_MSK_SCAN,
                               `AMUX_MSK_PIN_CFG, `AMUX_MSK_CTRL};
  int            scan_seq [3] = '{2, 5, 0};

  amux_sel #(.PIN_COUNT(6)) u_amux_sel (
    .clock(clock), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp), .sample_strobe(strobe),
    .ch0_pos_route(r0p), .ch0_neg_route(r0n), .ch1_pos_route(r1), .ch2_pos_route(r2),
    .ch3_pos_route(r3), .grp_neg_route(rgn), .grp_enable(grp_en),
    .resolution_mode_select(res_sel), .sample_b_active(samp_b),
    .pin_digital_mode_mask(dig_mask), .port_read_enable(rd_en));

  amux_core_model u_amux_core_model (
    .clock(clock), .rst_n(rst_n), .fire(fire), .gap(gap), .sample_strobe(strobe));

  // Free-running 200 MHz clock.
  always #2.5 clock = ~clock;

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // The ain field only means something for a pin route, so other kinds compare kind only.
  task automatic rchk(input string name, input amux_route_t s, input amux_kind_t k,
                      input logic [3:0] a);
    check({name, " kind"}, {30'h0, s.kind}, {30'h0, k});
    if (k == AMUX_RT_PIN) begin
      check({name, " input"}, {28'h0, s.ain}, {28'h0, a});
    end
  endtask : rchk

  // One APB transfer; an idle edge follows so no signal is driven twice in one step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clock);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      summarize();
    end
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // Routes follow a write one edge late, so one more edge passes before checking.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clock);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check("read data", q, {16'h0000, exp});
  endtask : rd_chk

  task automatic pulse();
    int n;
    fire <= 1'b1;
    gap  <= 4'($random(seed) & 3);
    @(posedge clock);
    fire <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (strobe !== 1'b1 && n < 40);
    if (n >= 40) begin
      n_mismatch++;
      summarize();
    end
    repeat (2) @(posedge clock);
  endtask : pulse

  task automatic grp(input logic [3:0] a, input logic [3:0] b, input logic [3:0] c);
    rchk("ch1 pos", r1, AMUX_RT_PIN, a);
    rchk("ch2 pos", r2, AMUX_RT_PIN, b);
    rchk("ch3 pos", r3, AMUX_RT_PIN, c);
  endtask : grp

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  // Some scenarios leave registers they touched set; later ones rewrite the fields that they check.
  initial begin
    seed = 34234;
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    fire = 1'b0;
    gap = 4'h0;
    n_mismatch = 0;
    num_checks = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 6; i++) rd_chk(8'(i * 4), `AMUX_RST_REG);
    grp(4'h0, 4'h1, 4'h2);
    rchk("ch0 neg", r0n, AMUX_RT_NREF, 4'h0);
    rchk("group neg", rgn, AMUX_RT_NREF, 4'h0);
    for (i = 0; i < 10; i++) begin
      v = (i < 5) ? 32'hFFFF_FFFF : $random(seed);
      wr(8'((i % 5) * 4), v);
      rd_chk(8'((i % 5) * 4), v[15:0] & masks[i % 5]);
      wr(8'((i % 5) * 4), 32'h0000_0000);
    end
    apb(1'b0, 8'h18, 32'h0000_0000);
    check("unmapped error", {31'h0, err}, 32'h1);
    wr(`AMUX_OFS_GRP_SEL, 32'h0000_0001);
    grp(4'h3, 4'h4, 4'h5);
    for (i = 0; i < 4; i++) begin
      wr(`AMUX_OFS_GRP_SEL, 32'(i << 1));
      rchk("group neg", rgn, (i < 2) ? AMUX_RT_NREF : AMUX_RT_OPEN, 4'h0);
    end
    wr(`AMUX_OFS_CTRL, 32'h0000_0004);
    check("group enable", {31'h0, grp_en}, 32'h0);
    check("resolution", {31'h0, res_sel}, 32'h1);
    wr(`AMUX_OFS_CTRL, 32'h0000_0000);
    check("group enable", {31'h0, grp_en}, 32'h1);
    for (i = 0; i < 8; i++) begin
      wr(`AMUX_OFS_CH0_SEL, 32'(i | ((i & 1) << 7)));
      rchk("ch0 pos", r0p, (i < 6) ? AMUX_RT_PIN : AMUX_RT_NREF, 4'(i));
      rchk("ch0 neg", r0n, (i & 1) ? AMUX_RT_PIN : AMUX_RT_NREF, 4'h1);
    end
    wr(`AMUX_OFS_GRP_SEL, 32'h0000_0100);
    wr(`AMUX_OFS_CH0_SEL, 32'h0000_8402);
    wr(`AMUX_OFS_CTRL, 32'h0000_0001);
    rchk("ch0 pos", r0p, AMUX_RT_PIN, 4'h2);
    pulse();
    check("sample b", {31'h0, samp_b}, 32'h1);
    rchk("ch0 pos", r0p, AMUX_RT_PIN, 4'h4);
    rchk("ch0 neg", r0n, AMUX_RT_PIN, 4'h1);
    grp(4'h3, 4'h4, 4'h5);
    pulse();
    grp(4'h0, 4'h1, 4'h2);
    wr(`AMUX_OFS_CTRL, 32'h0000_0000);
    pulse();
    check("sample b", {31'h0, samp_b}, 32'h0);
    wr(`AMUX_OFS_CH0_SEL, 32'h0000_0000);
    wr(`AMUX_OFS_PIN_CFG, 32'h0000_0001);
    rchk("ch0 pos", r0p, AMUX_RT_AGND, 4'h0);
    check("read path", {26'h0, rd_en}, 32'h1);
    wr(`AMUX_OFS_PIN_CFG, 32'h0000_0000);
    rchk("ch0 pos", r0p, AMUX_RT_PIN, 4'h0);
    check("read path", {26'h0, rd_en}, 32'h0);
    wr(`AMUX_OFS_SCAN, 32'h0000_0025);
    wr(`AMUX_OFS_CTRL, 32'h0000_0002);
    rchk("scan pos", r0p, AMUX_RT_PIN, 4'h0);
    for (i = 0; i < 3; i++) begin
      pulse();
      rchk("scan pos", r0p, AMUX_RT_PIN, 4'(scan_seq[i]));
    end
    summarize();
  end
endmodule : tb_top
